// file: common/dopc_regs.svh
// Register offsets, field positions, reset values and timing counts of the output pacing control.
// Assumes a 32-bit classic Wishbone slave with byte addresses on the low address bits.
`ifndef DOPC_REGS_SVH
`define DOPC_REGS_SVH

// Register byte offsets
`define DOPC_ADR_CTRL      8'h00
`define DOPC_ADR_CMD       8'h04
`define DOPC_ADR_DIVISOR   8'h08
`define DOPC_ADR_STOPCNT   8'h0c
`define DOPC_ADR_FIFO      8'h10
`define DOPC_ADR_SINGLE    8'h14
`define DOPC_ADR_THRESH    8'h18
`define DOPC_ADR_STATUS    8'h1c
`define DOPC_ADR_CODES     8'h20

// Control register fields
`define DOPC_CTRL_EXTCLK   0
`define DOPC_CTRL_TRIG_LO  1
`define DOPC_CTRL_TRIG_HI  2
`define DOPC_CTRL_RISING   3
`define DOPC_CTRL_THREXT   4
`define DOPC_CTRL_TWOCH    5
`define DOPC_CTRL_FIRST1   6
`define DOPC_CTRL_WAVE     7

// Command register fields
`define DOPC_CMD_START     0
`define DOPC_CMD_ORDERLY   1
`define DOPC_CMD_ABRUPT    2
`define DOPC_CMD_FIFORST   3
`define DOPC_CMD_CLRUND    4

// Single-value register fields
`define DOPC_SINGLE_CH     16

// Status register fields
`define DOPC_STAT_STARVED  2
`define DOPC_STAT_UNDER    3
`define DOPC_STAT_ORDERLY  4
`define DOPC_STAT_CNT_LO   16

// Reset values; the 0 V code is power-up only, reset keeps the converter codes
`define DOPC_CODE_0V       16'h8000
`define DOPC_THRESH_RST    8'h80
`define DOPC_DIVISOR_RST   24'h004e20
`define DOPC_STOPCNT_RST   24'h000000

// Timing
`define DOPC_CLK_HZ        100000000
`define DOPC_TB_HZ         20000000
`define DOPC_TB_DIV        (`DOPC_CLK_HZ / `DOPC_TB_HZ)
`define DOPC_MAX_RATE_HZ   500000
`define DOPC_DIV_MIN       (`DOPC_TB_HZ / `DOPC_MAX_RATE_HZ)

`endif

// file: common/dopc_pkg.sv
// Types shared by the output pacing control.
// Assumes nothing beyond a SystemVerilog package scope.
`default_nettype none
package dopc_pkg;

   typedef enum logic [1:0] {
      DOPC_IDLE  = 2'b00,
      DOPC_ARMED = 2'b01,
      DOPC_RUN   = 2'b11
   } dopc_state_e;

   typedef enum logic [1:0] {
      DOPC_TRIG_SW     = 2'b00,
      DOPC_TRIG_DIGITAL = 2'b01,
      DOPC_TRIG_ANALOG = 2'b10
   } dopc_trig_e;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } dopc_wb_req_s;

endpackage
`default_nettype wire

// file: logic/dopc_top.sv
// Two-channel output converter pacing control with Wishbone register access and sample FIFO.
// Assumes all inputs synchronous to clk_i; threshold comparator with hysteresis sits outside.
//
// Operation
// R1 - Sixteen-bit fixed sample codes per channel
// R2 - Channel list: one or two, either first
// R3 - Two-stage code register, whole transfer
// R4 - Codes power up 0 V, reset keeps them
// R5 - All listed converters update together
// R6 - 24-bit down-counter from 20 MHz base
// R7 - Active-low pulse, convert on falling edge
// R8 - Rate limited 1.2 Hz to 500 kHz
// R9 - External clock falling edge paces conversion
// R10 - Software start write is the trigger
// R11 - Selectable edge on external digital trigger
// R12 - Analog threshold crossing, selectable direction
// R13 - Eight-bit threshold code, fixed hysteresis
// R14 - Software puts trigger channel first
// R15 - Single value: direct write, unstoppable
// R16 - Streaming and waveform continuous sub-modes
// R17 - Streaming may end when data runs out
// R18 - Orderly stop finishes count, ignores triggers
// R19 - Abrupt stop halts at once, ignores triggers
// R20 - Even samples entry zero, odd entry one
// R21 - FIFO count tracks loads, reads, reset
// R22 - Waveform mode retransmits pattern when empty
// R23 - Empty pacing holds code; later write flags
// R24 - Pacing ignored until trigger detected
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
`include "dopc_regs.svh"

module dopc_top #(
   parameter int AW = 12
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire dopc_pkg::dopc_wb_req_s wb_req_i,
   output logic                       wb_ack_o,
   output logic [31:0]                wb_dat_o,
   input  wire logic                  ext_clk_i,
   input  wire logic                  ext_trig_i,
   input  wire logic                  thr_cmp_i,
   output logic [15:0]                conv0_code_o,
   output logic [15:0]                conv1_code_o,
   output logic                       conv_load_o,
   output logic                       pace_n_o,
   output logic [7:0]                 thr_code_o,
   output logic                       thr_src_ext_o,
   output logic                       running_o
);
   import dopc_pkg::*;

   localparam int DEPTH = 1 << AW;

   typedef struct packed {
      logic              ack;
      logic [31:0]       rdata;
      logic              ext_clk;
      dopc_trig_e        trig_src;
      logic              rising;
      logic              thr_ext;
      logic              two_ch;
      logic              first_one;
      logic              wave;
      logic [23:0]       divisor;
      logic [23:0]       stop_cnt;
      logic [7:0]        thr_code;
      dopc_state_e       state;
      logic [2:0]        tb_cnt;
      logic [23:0]       pace_cnt;
      logic              pace_n;
      logic              pace_prev;
      logic              ext_prev;
      logic              trig_prev;
      logic              cmp_prev;
      logic              orderly;
      logic [23:0]       done_cnt;
      logic              starved;
      logic              underflow;
      logic [AW:0]       wr_ptr;
      logic [AW-1:0]     rd_ptr;
      logic [AW:0]       count;
      logic              load;
      logic [15:0]       hold0;
      logic [15:0]       hold1;
      logic [15:0]       code0;
      logic [15:0]       code1;
   } dopc_state_s;

   localparam dopc_state_s PWRUP = '{
      pace_n:    1'b1,
      pace_prev: 1'b1,
      ext_prev:  1'b1,
      divisor:   `DOPC_DIVISOR_RST,
      stop_cnt:  `DOPC_STOPCNT_RST,
      thr_code:  `DOPC_THRESH_RST,
      trig_src:  DOPC_TRIG_SW,
      state:     DOPC_IDLE,
      hold0:     `DOPC_CODE_0V,
      hold1:     `DOPC_CODE_0V,
      code0:     `DOPC_CODE_0V,
      code1:     `DOPC_CODE_0V,
      default:   '0
   };

   dopc_state_s state_q = PWRUP;
   dopc_state_s state_d;

   logic [31:0]      fifo_mem [DEPTH/2];
   logic             mem_we;

   // Reset everything except the held converter codes
   function automatic dopc_state_s reset_val(input dopc_state_s cur);
      dopc_state_s r;
      r       = PWRUP;
      r.hold0 = cur.hold0; // R4
      r.hold1 = cur.hold1;
      r.code0 = cur.code0;
      r.code1 = cur.code1;
      return r;
   endfunction

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return m;
   endfunction

   // One sample from the word-packed store, even sample in the low half
   function automatic logic [15:0] sample(input logic [AW-1:0] idx);
      logic [31:0] w;
      w = fifo_mem[idx[AW-1:1]];
      return idx[0] ? w[31:16] : w[15:0];
   endfunction

   // Edge detect with a chosen direction
   function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
      return rising ? (!prev && cur) : (prev && !cur);
   endfunction

   logic             acc;
   logic             wr;
   logic [31:0]      ctrl_word;
   logic [31:0]      status_word;
   logic [31:0]      merged;
   logic             tb_tick;
   logic             pace_evt;
   logic             trig_hit;
   logic             push;
   logic [AW:0]      need;
   logic [AW:0]      pop_n;
   logic [15:0]      s_even;
   logic [15:0]      s_odd;
   logic [23:0]      div_eff;

   always_comb begin
      state_d       = state_q;
      state_d.ack   = 1'b0;
      state_d.load  = 1'b0;
      mem_we        = 1'b0;
      push          = 1'b0;
      pop_n         = '0;
      acc           = wb_req_i.cyc && wb_req_i.stb && !state_q.ack;
      wr            = acc && wb_req_i.we;
      ctrl_word     = {24'h000000, state_q.wave, state_q.first_one, state_q.two_ch, state_q.thr_ext,
                       state_q.rising, state_q.trig_src, state_q.ext_clk};
      status_word   = '0;
      status_word[1:0]                  = state_q.state;
      status_word[`DOPC_STAT_STARVED]   = state_q.starved;
      status_word[`DOPC_STAT_UNDER]     = state_q.underflow;
      status_word[`DOPC_STAT_ORDERLY]   = state_q.orderly;
      status_word[`DOPC_STAT_CNT_LO +: AW+1] = state_q.count; // R21
      merged        = '0;
      div_eff       = (state_q.divisor < 24'(`DOPC_DIV_MIN)) ? 24'(`DOPC_DIV_MIN) : state_q.divisor; // R8
      need          = state_q.two_ch ? (AW+1)'(2) : (AW+1)'(1); // R2
      s_even        = sample(state_q.rd_ptr);
      s_odd         = sample(state_q.rd_ptr + AW'(1));

      // Wishbone classic slave: one-cycle ack, unmapped reads zero
      if (acc) begin
         state_d.ack   = 1'b1;
         state_d.rdata = '0;
         if (!wb_req_i.we) begin
            case (wb_req_i.adr)
               `DOPC_ADR_CTRL:    state_d.rdata = ctrl_word;
               `DOPC_ADR_DIVISOR: state_d.rdata = {8'h00, state_q.divisor};
               `DOPC_ADR_STOPCNT: state_d.rdata = {8'h00, state_q.stop_cnt};
               `DOPC_ADR_THRESH:  state_d.rdata = {24'h000000, state_q.thr_code};
               `DOPC_ADR_STATUS:  state_d.rdata = status_word;
               `DOPC_ADR_CODES:   state_d.rdata = {state_q.code1, state_q.code0};
               default:           state_d.rdata = '0;
            endcase
         end
      end

      // Register writes
      if (wr) begin
         case (wb_req_i.adr)
            `DOPC_ADR_CTRL: begin
               merged             = merge(ctrl_word, wb_req_i.dat, wb_req_i.sel);
               state_d.ext_clk    = merged[`DOPC_CTRL_EXTCLK];
               state_d.trig_src   = dopc_trig_e'(merged[`DOPC_CTRL_TRIG_HI:`DOPC_CTRL_TRIG_LO]);
               state_d.rising     = merged[`DOPC_CTRL_RISING];
               state_d.thr_ext    = merged[`DOPC_CTRL_THREXT];
               state_d.two_ch     = merged[`DOPC_CTRL_TWOCH];
               state_d.first_one  = merged[`DOPC_CTRL_FIRST1];
               state_d.wave       = merged[`DOPC_CTRL_WAVE]; // R16
            end
            `DOPC_ADR_DIVISOR: begin
               merged          = merge({8'h00, state_q.divisor}, wb_req_i.dat, wb_req_i.sel);
               state_d.divisor = merged[23:0]; // R6
            end
            `DOPC_ADR_STOPCNT: begin
               merged           = merge({8'h00, state_q.stop_cnt}, wb_req_i.dat, wb_req_i.sel);
               state_d.stop_cnt = merged[23:0];
            end
            `DOPC_ADR_THRESH: begin
               if (wb_req_i.sel[0]) begin
                  state_d.thr_code = wb_req_i.dat[7:0]; // R13
               end
            end
            `DOPC_ADR_SINGLE: begin
               // Direct write of one converter, no pacing or trigger
               if (wb_req_i.sel[1:0] == 2'b11) begin
                  if (wb_req_i.dat[`DOPC_SINGLE_CH]) begin
                     state_d.hold1 = wb_req_i.dat[15:0]; // R15
                     state_d.code1 = wb_req_i.dat[15:0];
                  end else begin
                     state_d.hold0 = wb_req_i.dat[15:0]; // R15
                     state_d.code0 = wb_req_i.dat[15:0];
                  end
               end
            end
            `DOPC_ADR_FIFO: begin
               // Two packed samples per word; dropped when no room
               if (wb_req_i.sel == 4'hf && state_q.count <= (AW+1)'(DEPTH - 2)) begin
                  push   = 1'b1;
                  mem_we = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // Timebase enable and internal pacing counter
      tb_tick = (state_q.tb_cnt == 3'(`DOPC_TB_DIV - 1));
      state_d.tb_cnt = tb_tick ? 3'h0 : state_q.tb_cnt + 3'h1;
      if (state_q.state == DOPC_IDLE) begin
         state_d.pace_cnt = div_eff - 24'h000001;
         state_d.pace_n   = 1'b1;
      end else if (tb_tick) begin
         if (state_q.pace_cnt == 24'h000000) begin
            state_d.pace_cnt = div_eff - 24'h000001; // R6
            state_d.pace_n   = 1'b0; // R7
         end else begin
            state_d.pace_cnt = state_q.pace_cnt - 24'h000001;
            state_d.pace_n   = 1'b1;
         end
      end
      state_d.pace_prev = state_q.pace_n;
      state_d.ext_prev  = ext_clk_i;
      state_d.trig_prev = ext_trig_i;
      state_d.cmp_prev  = thr_cmp_i;
      pace_evt = state_q.ext_clk ? (state_q.ext_prev && !ext_clk_i) // R9
                                 : (state_q.pace_prev && !state_q.pace_n); // R7

      // Hardware trigger detection
      case (state_q.trig_src)
         DOPC_TRIG_DIGITAL: trig_hit = edge_hit(state_q.trig_prev, ext_trig_i, state_q.rising); // R11
         DOPC_TRIG_ANALOG:  trig_hit = edge_hit(state_q.cmp_prev, thr_cmp_i, state_q.rising); // R12
         default:           trig_hit = 1'b0;
      endcase

      // Operation sequencing
      case (state_q.state)
         DOPC_IDLE: begin
            if (wr && wb_req_i.adr == `DOPC_ADR_CMD && wb_req_i.sel[0] && wb_req_i.dat[`DOPC_CMD_START]) begin
               state_d.done_cnt = '0;
               state_d.orderly  = 1'b0;
               state_d.state    = (state_q.trig_src == DOPC_TRIG_SW) ? DOPC_RUN : DOPC_ARMED; // R10
            end
         end
         DOPC_ARMED: begin
            if (trig_hit) begin
               state_d.state = DOPC_RUN; // R24
            end
         end
         DOPC_RUN: begin
            if (pace_evt) begin
               if (state_q.count >= need) begin
                  // Even sample to entry zero, odd to entry one
                  if (state_q.first_one) begin
                     state_d.hold1 = s_even; // R20
                     if (state_q.two_ch) begin
                        state_d.hold0 = s_odd;
                     end
                  end else begin
                     state_d.hold0 = s_even; // R20
                     if (state_q.two_ch) begin
                        state_d.hold1 = s_odd;
                     end
                  end
                  state_d.load     = 1'b1; // R3
                  pop_n            = need;
                  state_d.rd_ptr   = state_q.rd_ptr + need[AW-1:0];
                  state_d.done_cnt = state_q.done_cnt + 24'(need);
                  state_d.starved  = 1'b0;
               end else begin
                  state_d.starved = 1'b1; // R23 R17
               end
            end
            if (state_q.orderly && state_q.done_cnt >= state_q.stop_cnt) begin
               state_d.state = DOPC_IDLE; // R18
            end
         end
         default: begin
            state_d.state = DOPC_IDLE;
         end
      endcase

      // Stop commands; idle state ignores all triggers
      if (wr && wb_req_i.adr == `DOPC_ADR_CMD && wb_req_i.sel[0]) begin
         if (wb_req_i.dat[`DOPC_CMD_ORDERLY] && state_q.state != DOPC_IDLE) begin
            state_d.orderly = 1'b1; // R18
            if (state_q.state == DOPC_ARMED) begin
               state_d.state = DOPC_IDLE;
            end
         end
         if (wb_req_i.dat[`DOPC_CMD_ABRUPT]) begin
            state_d.state   = DOPC_IDLE; // R19
            state_d.load    = 1'b0;
            state_d.orderly = 1'b0;
         end
         if (wb_req_i.dat[`DOPC_CMD_CLRUND]) begin
            state_d.underflow = 1'b0;
         end
      end

      // Transfer the whole held pair at once
      if (state_q.load) begin
         state_d.code0 = state_q.hold0; // R3 R5
         state_d.code1 = state_q.hold1;
      end

      // FIFO bookkeeping; set of underflow wins over its clear
      state_d.count = state_q.count + (push ? (AW+1)'(2) : (AW+1)'(0)) - pop_n; // R21
      if (push) begin
         state_d.wr_ptr = state_q.wr_ptr + (AW+1)'(2);
         if (state_q.starved) begin
            state_d.underflow = 1'b1; // R23
            state_d.starved   = 1'b0;
         end
      end
      if (state_q.wave && pop_n != '0 && state_q.count == pop_n && !push) begin
         state_d.rd_ptr = '0; // R22
         state_d.count  = state_q.wr_ptr;
      end
      if (wr && wb_req_i.adr == `DOPC_ADR_CMD && wb_req_i.sel[0] && wb_req_i.dat[`DOPC_CMD_FIFORST]) begin
         state_d.wr_ptr  = '0; // R21
         state_d.rd_ptr  = '0;
         state_d.count   = '0;
         state_d.starved = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= reset_val(state_q); // R4
      end else begin
         state_q <= state_d;
      end
   end

   // Sample store, one packed word per host load
   always_ff @(posedge clk_i) begin
      if (mem_we && !rst_i) begin
         fifo_mem[state_q.wr_ptr[AW-1:1]] <= wb_req_i.dat; // R1
      end
   end

   assign wb_ack_o      = state_q.ack;
   assign wb_dat_o      = state_q.rdata;
   assign conv0_code_o  = state_q.code0;
   assign conv1_code_o  = state_q.code1;
   assign conv_load_o   = state_q.load;
   assign pace_n_o      = state_q.pace_n;
   assign thr_code_o    = state_q.thr_code;
   assign thr_src_ext_o = state_q.thr_ext;
   assign running_o     = state_q.state[0];

endmodule
`default_nettype wire

// file: verification/dopc_chk.sv
// Checker: bus handshake, pacing pulse and converter update relations.
// Assumes it is bound onto dopc_top and sees only its ports.
`default_nettype none
`include "dopc_regs.svh"
module dopc_chk (
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire dopc_pkg::dopc_wb_req_s wb_req_i,
   input wire logic                   wb_ack_o,
   input wire logic [15:0]            conv0_code_o,
   input wire logic [15:0]            conv1_code_o,
   input wire logic                   conv_load_o,
   input wire logic                   pace_n_o,
   input wire logic [7:0]             thr_code_o,
   input wire logic                   thr_src_ext_o,
   input wire logic                   running_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import dopc_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   endsequence
   sequence s_wr;
      wb_ack_o && wb_req_i.we && wb_req_i.sel[0];
   endsequence
   sequence s_low5;
      (!pace_n_o)[*5] ##1 pace_n_o;
   endsequence
   property p_ack_one;
      s_take |=> wb_ack_o;
   endproperty
   property p_ack_drop;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_hold;
      $changed(conv0_code_o) || $changed(conv1_code_o) |-> $past(conv_load_o) || $past(wb_req_i.cyc);
   endproperty
   property p_pace;
      $fell(pace_n_o) |-> s_low5 or (##[0:5] !running_o);
   endproperty
   property p_idle;
      !running_o && !$past(running_o) && !$past(running_o, 2) && !$past(wb_req_i.cyc) |-> !conv_load_o;
   endproperty
   property p_load;
      conv_load_o |=> !conv_load_o;
   endproperty
   property p_thr;
      s_wr ##0 wb_req_i.adr == `DOPC_ADR_THRESH |=> thr_code_o == $past(wb_req_i.dat[7:0]);
   endproperty
   property p_src;
      s_wr ##0 wb_req_i.adr == `DOPC_ADR_CTRL |=> thr_src_ext_o == $past(wb_req_i.dat[4]);
   endproperty
   property p_abort;
      s_wr ##0 wb_req_i.adr == `DOPC_ADR_CMD && wb_req_i.dat[2] && !wb_req_i.dat[0] |-> ##[0:2] !running_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("no ack after request");
   a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
   a_hold: assert property (p_hold) else $error("code changed without transfer");
   a_pace: assert property (p_pace) else $error("pacing pulse not five cycles low");
   a_idle: assert property (p_idle) else $error("converter load while stopped");
   a_load: assert property (p_load) else $error("load pulse too long");
   a_thr: assert property (p_thr) else $error("threshold code not written");
   a_src: assert property (p_src) else $error("threshold source not following");
   a_abort: assert property (p_abort) else $error("abrupt stop did not halt");
endmodule
`default_nettype wire

// file: verification/dopc_ext_model.sv
// Far side model: external pacing clock, digital trigger line, threshold comparator.
// Assumes the bench calls its tasks just after a rising clock edge.
`default_nettype none
module dopc_ext_model (
   input  wire logic clk_i,
   output logic      ext_clk_o,
   output logic      ext_trig_o,
   output logic      thr_cmp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ext_clk_o = 1'b1;
      ext_trig_o = 1'b0;
      thr_cmp_o = 1'b0;
   end
   // One falling edge per conversion, idle high
   task automatic pace();
      @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask
   // Level of the chosen trigger line
   task automatic level(input logic ana, input logic v);
      @(posedge clk_i);
      if (ana)
         thr_cmp_o <= v;
      else
         ext_trig_o <= v;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// file: verification/dac_output_pacing_control_test.sv
// Bench: Wishbone master and queue model compared with the pacing control.
// Assumes dopc_top with AW of 4 and the far side model beside it.
`default_nettype none
`include "dopc_regs.svh"
module dac_output_pacing_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dopc_pkg::*;
   logic         clk_i, rst_i, ack, ext_clk, ext_trig, thr_cmp, load, pace_n, src_ext, run;
   dopc_wb_req_s req;
   logic [31:0]  rdat, d, v;
   logic [15:0]  c0, c1;
   logic [15:0]  e [2];
   logic [7:0]   thr;
   logic [15:0]  q [$];
   int           bad_count, n_compared, t0;
   int           cyc = 0;
   int           dv [3] = '{40, 10, 50};
   int           per [3] = '{200, 200, 250};
   dopc_top #(.AW(4)) dopc_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat),
      .ext_clk_i(ext_clk), .ext_trig_i(ext_trig), .thr_cmp_i(thr_cmp), .conv0_code_o(c0),
      .conv1_code_o(c1), .conv_load_o(load), .pace_n_o(pace_n), .thr_code_o(thr),
      .thr_src_ext_o(src_ext), .running_o(run)
   );
   dopc_ext_model ext_inst (.clk_i(clk_i), .ext_clk_o(ext_clk), .ext_trig_o(ext_trig), .thr_cmp_o(thr_cmp));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cyc <= cyc + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      req <= '{1'b1, 1'b1, we, a, 4'hf, wd};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] x);
      wb(1'b1, a, x, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      wb(1'b0, a, 32'h0, d);
      chk(d, x);
   endtask
   task automatic sts(input int lo, input int n, input logic [31:0] x);
      wb(1'b0, `DOPC_ADR_STATUS, 32'h0, d);
      chk((d >> lo) & ((32'h1 << n) - 1), x);
   endtask
   task automatic ld(input int n);
      w(`DOPC_ADR_CMD, 32'h8);
      q.delete();
      repeat (n) begin
         v = $urandom();
         w(`DOPC_ADR_FIFO, v);
         q.push_back(v[15:0]);
         q.push_back(v[31:16]);
      end
   endtask
   task automatic step(input logic two, input logic f, input logic wv);
      logic [15:0] s;
      ext_inst.pace();
      if (q.size() > int'(two)) begin
         s = q.pop_front();
         e[f] = s;
         if (wv)
            q.push_back(s);
         if (two)
            e[!f] = q.pop_front();
      end
      chk({c1, c0}, {e[1], e[0]});
   endtask
   task automatic fall();
      while (pace_n !== 1'b1) begin
         @(posedge clk_i);
      end
      while (pace_n !== 1'b0) begin
         @(posedge clk_i);
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      conclude();
   end
   initial begin
      req = '0;
      rst_i = 1'b1;
      bad_count = 0;
      n_compared = 0;
      e = '{16'h8000, 16'h8000};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      v = $urandom(32'hd55f);
      rc(`DOPC_ADR_CODES, 32'h80008000);
      rc(`DOPC_ADR_DIVISOR, 32'h4e20);
      rc(8'h40, 32'h0);
      chk({24'h0, thr}, 32'h80);
      v = $urandom() & 32'hff;
      w(`DOPC_ADR_THRESH, v);
      chk({24'h0, thr}, v);
      $display("reset test done");
      for (int ch = 0; ch < 2; ch++) begin
         v = $urandom();
         e[ch] = v[15:0];
         w(`DOPC_ADR_SINGLE, {15'h0, ch[0], v[15:0]});
         chk({c1, c0}, {e[1], e[0]});
      end
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({c1, c0}, {e[1], e[0]});
      $display("single test done");
      for (int f = 0; f < 2; f++) begin
         w(`DOPC_ADR_CTRL, 32'h21 | (f << 6));
         ld(3);
         sts(16, 13, 6);
         w(`DOPC_ADR_CMD, 32'h1);
         sts(0, 2, 3);
         for (int k = 0; k < 3; k++) begin
            step(1'b1, f[0], 1'b0);
            sts(16, 13, 4 - 2 * k);
         end
         step(1'b1, f[0], 1'b0);
         sts(2, 2, 1);
         w(`DOPC_ADR_FIFO, $urandom());
         sts(3, 1, 1);
         w(`DOPC_ADR_CMD, 32'h10);
         sts(3, 1, 0);
         w(`DOPC_ADR_CMD, 32'h4);
         sts(0, 2, 0);
      end
      $display("streaming test done");
      w(`DOPC_ADR_CTRL, 32'h1);
      ld(2);
      w(`DOPC_ADR_STOPCNT, 32'h3);
      w(`DOPC_ADR_CMD, 32'h1);
      step(1'b0, 1'b0, 1'b0);
      w(`DOPC_ADR_CMD, 32'h2);
      sts(4, 1, 1);
      step(1'b0, 1'b0, 1'b0);
      step(1'b0, 1'b0, 1'b0);
      sts(0, 2, 0);
      ext_inst.pace();
      chk({c1, c0}, {e[1], e[0]});
      $display("orderly test done");
      ld(1);
      for (int s = 1; s < 3; s++) begin
         for (int r = 0; r < 2; r++) begin
            ext_inst.level(s == 2, !r[0]);
            w(`DOPC_ADR_CTRL, 1 | (s << 1) | (r << 3) | ((s - 1) << 4));
            chk({31'h0, src_ext}, s - 1);
            w(`DOPC_ADR_CMD, 32'h1);
            sts(0, 2, 1);
            ext_inst.pace();
            chk({c1, c0}, {e[1], e[0]});
            ext_inst.level(s == 2, r[0]);
            sts(0, 2, 3);
            w(`DOPC_ADR_CMD, 32'h4);
            ext_inst.level(s == 2, !r[0]);
            ext_inst.level(s == 2, r[0]);
            sts(0, 2, 0);
         end
      end
      $display("trigger test done");
      for (int i = 0; i < 3; i++) begin
         w(`DOPC_ADR_CTRL, 32'h0);
         w(`DOPC_ADR_DIVISOR, dv[i]);
         w(`DOPC_ADR_CMD, 32'h1);
         fall();
         t0 = cyc;
         fall();
         chk(cyc - t0, per[i]);
         w(`DOPC_ADR_CMD, 32'h4);
      end
      $display("pacing test done");
      w(`DOPC_ADR_CTRL, 32'h81);
      ld(1);
      w(`DOPC_ADR_CMD, 32'h1);
      repeat (5) step(1'b0, 1'b0, 1'b1);
      w(`DOPC_ADR_CMD, 32'h4);
      $display("waveform test done");
      conclude();
   end
endmodule
bind dopc_top dopc_chk dopc_chk_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
   .conv0_code_o(conv0_code_o), .conv1_code_o(conv1_code_o), .conv_load_o(conv_load_o),
   .pace_n_o(pace_n_o), .thr_code_o(thr_code_o), .thr_src_ext_o(thr_src_ext_o), .running_o(running_o)
);
`default_nettype wire
